// *** rtl/smr_pkg.sv ***
package smr_pkg;
  // frame layout
  localparam int FRAME_W = 16;
  localparam int CNT_W = 5;
  localparam int TOP_HI = 15;
  localparam int TOP_LO = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int GLOBAL_BIT = 8;
  localparam int SAFE_REL_BIT = 7;
  localparam int DATA_HI = 7;
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 3;
  localparam int CODE_HI = 2;
  localparam logic [4:0] MODE_ADDR = 5'h0e;
  localparam logic [4:0] REGU_ADDR = 5'h0f;
  localparam logic [1:0] TOP_READ_CODE = 2'h0;
  localparam logic [1:0] TOP_READ_STATE = 2'h3;
  localparam logic [1:0] TOP_WRITE = 2'h1;

  // device modes
  localparam logic [4:0] MODE_INIT = 5'h00;
  localparam logic [4:0] MODE_NORMAL_REQ = 5'h02;
  localparam logic [4:0] MODE_NORMAL = 5'h03;
  localparam int MODE_LP_BIT = 4;
  localparam logic [2:0] MODE_LP_OFF_HEAD = 3'h3;

  // regulator control register
  localparam int AUX_HI = 7;
  localparam int AUX_LO = 6;
  localparam int CAN_HI = 4;
  localparam int CAN_LO = 3;
  localparam int BAL_EN_BIT = 2;
  localparam int BAL_AUTO_BIT = 1;
  localparam int OFF_EN_BIT = 0;
  localparam logic [7:0] REGU_RESET = 8'h00;
  localparam logic [7:0] REGU_WR_MASK = 8'hdf;
  localparam logic [1:0] SUP_OFF = 2'h0;
  localparam logic [1:0] SUP_QUIET = 2'h1;
  localparam logic [1:0] SUP_REPORT = 2'h2;
  localparam logic [1:0] SUP_FAST = 2'h3;
  localparam logic [1:0] CAN_DEBUG_DEFAULT = SUP_QUIET;

  // random code source
  localparam logic [7:0] LFSR_SEED = 8'h5a;
  localparam logic [7:0] LFSR_TAPS = 8'hb8;

  // blanking times
  localparam int CLK_PERIOD_NS = 100;
  localparam int BLANK_LONG_NS = 1_000_000;
  localparam int BLANK_SHORT_NS = 25_000;
  localparam int BLANK_LONG_CYC = (BLANK_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_SHORT_CYC = (BLANK_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_W = 14;
endpackage : smr_pkg

// *** rtl/smr_rnd_gen.sv ***
`timescale 1ns/1ns
module smr_rnd_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // code out
  output logic [2:0] code
);
  logic [7:0] lfsr;
  logic [7:0] next_lfsr;

  always_comb begin
    next_lfsr = {lfsr[6:0], ^(lfsr & smr_pkg::LFSR_TAPS)};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lfsr <= smr_pkg::LFSR_SEED;
    end else begin
      lfsr <= next_lfsr;
    end
  end

  assign code = lfsr[2:0];
endmodule : smr_rnd_gen

// *** rtl/smr_spi_port.sv ***
`timescale 1ns/1ns
module smr_spi_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // spi pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // frame side
  input wire logic [15:0] resp_word,
  output logic [15:0] rx_word,
  output logic [1:0] lead_bits,
  output logic frame_start,
  output logic frame_done
);
  logic sclk_d;
  logic cs_d;
  logic [4:0] bit_count;
  logic [4:0] next_bit_count;
  logic [15:0] next_rx;
  logic [1:0] next_lead;
  logic next_miso;
  logic next_start;
  logic next_done;
  logic rise;
  logic fall;

  always_comb begin
    rise = sclk && !sclk_d && !cs_n;
    fall = !sclk && sclk_d && !cs_n;
    next_bit_count = bit_count;
    next_rx = rx_word;
    next_lead = lead_bits;
    next_miso = miso;
    next_start = 1'b0;
    next_done = 1'b0;
    if (!cs_n && cs_d) begin
      next_bit_count = '0;
      next_start = 1'b1;
      next_miso = resp_word[smr_pkg::FRAME_W - 1];
    end else if (cs_n) begin
      next_miso = 1'b0;
      next_done = !cs_d && (bit_count == 5'(smr_pkg::FRAME_W));
    end else if (rise) begin
      next_rx = {rx_word[14:0], mosi};
      if (bit_count == 5'h01) begin
        next_lead = {rx_word[0], mosi};
      end
      if (bit_count != 5'h1f) begin
        next_bit_count = bit_count + 5'h01;
      end
    end else if (fall && bit_count < 5'(smr_pkg::FRAME_W)) begin
      next_miso = resp_word[4'(smr_pkg::FRAME_W - 1 - int'(bit_count))];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sclk_d <= 1'b0;
      cs_d <= 1'b1;
      bit_count <= '0;
      rx_word <= '0;
      lead_bits <= '0;
      miso <= 1'b0;
      frame_start <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      sclk_d <= sclk;
      cs_d <= cs_n;
      bit_count <= next_bit_count;
      rx_word <= next_rx;
      lead_bits <= next_lead;
      miso <= next_miso;
      frame_start <= next_start;
      frame_done <= next_done;
    end
  end
endmodule : smr_spi_port

// *** rtl/smr_mode_reg_ctrl.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// RULE_01 - global commands: address 01110 in bits 13-9, with bits 15-14 and bit 7
// RULE_02 - host always sends bit 8 high in global commands
// RULE_03 - random-code entry only if selected while in initialisation mode
// RULE_04 - in normal mode 0x1D00/0x1D80 return the 3-bit code in bits 2-0
// RULE_05 - host writes low-power request with inverted last code in bits 2-0
// RULE_06 - unprotected 0x5C60 enters supply-off low power, no sensing, no forced wake
// RULE_07 - 0x1D00 leaves debug, keeps fail-safe; replies status, mode, code
// RULE_08 - 0x1D80 releases fail-safe output; replies status, mode, code
// RULE_09 - 0xDD00 leaves debug; replies mode, fail-safe bit 1, debug bit 0
// RULE_10 - 0xDD80 keeps debug, releases fail-safe; same reply as 0xDD00
// RULE_11 - mode codes: 00000 init, 00001 flash, 00010 normal request, 00011 normal, 1xxxx low power
// RULE_12 - reply bit 1 is 0 while fail-safe driver active, 1 when off
// RULE_13 - reply bit 0 is 1 while debug mode active
// RULE_14 - write frame with address 01111 loads regulator register from second byte
// RULE_15 - aux field: off, quiet 1 ms, reported 1 ms, reported 25 us blanking
// RULE_16 - can supply field: same codes, quiet code is default in debug
// RULE_17 - bit 2 enables external ballast transistor
// RULE_18 - bit 1 allows automatic ballast above about 60 mA load
// RULE_19 - bit 0 clear blocks entry into supply-off low power
// RULE_20 - low bits of low-power write carry the code only when selected
// RULE_21 - host wakes supply-on low power by writing 0x5C10
// RULE_22 - host clears wake-up flags before requesting low power
// RULE_23 - with code protection, ignore low-power write with wrong inverted code
// RULE_24 - aux and can supply fields reset to zero, regulators off
module smr_mode_reg_ctrl #(
  parameter int BLANK_LONG_CYCLES = smr_pkg::BLANK_LONG_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // spi pins
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  // device state inputs
  input wire logic [7:0] fix_status,
  input wire logic lowpower_random_select,
  input wire logic debug_strap,
  input wire logic safe_activate,
  input wire logic mode_load,
  input wire logic [4:0] mode_load_value,
  input wire logic load_over_threshold,
  input wire logic [1:0] supply_fault,
  // state and control outputs
  output logic [4:0] device_mode,
  output logic debug_mode,
  output logic safe_off,
  output logic [7:0] regulator_control,
  output logic [1:0] supply_on,
  output logic [1:0] supply_flag,
  output logic ballast_on
);
  logic [15:0] rx_word;
  logic [15:0] resp_word;
  logic [1:0] lead_bits;
  logic frame_start;
  logic frame_done;
  logic [2:0] rnd_code;
  logic [2:0] shown_code;
  logic [2:0] last_code;
  logic code_valid;
  logic rnd_sel;
  logic strap_done;
  logic [2:0] next_shown_code;
  logic [2:0] next_last_code;
  logic next_code_valid;
  logic next_rnd_sel;
  logic next_strap_done;
  logic [4:0] next_device_mode;
  logic next_debug_mode;
  logic next_safe_off;
  logic [7:0] next_regulator_control;
  logic next_ballast_on;
  logic [4:0] addr;
  logic [1:0] top;
  logic [4:0] wr_mode;
  logic is_global;
  logic code_read;
  logic mode_wr;
  logic regu_wr;
  logic code_ok;
  logic lp_off_req;
  logic lp_on_req;
  logic mode_accept;

  smr_spi_port u_spi (
    .core_clk(core_clk),
    .rstn(rstn),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .resp_word(resp_word),
    .rx_word(rx_word),
    .lead_bits(lead_bits),
    .frame_start(frame_start),
    .frame_done(frame_done)
  );

  smr_rnd_gen u_rnd (
    .core_clk(core_clk),
    .rstn(rstn),
    .code(rnd_code)
  );

  // reply: low bits follow the lead bits already received
  always_comb begin
    if (lead_bits == smr_pkg::TOP_READ_STATE) begin
      resp_word = {fix_status, device_mode, 1'b0, safe_off, debug_mode}; // [RULE_09] [RULE_12] [RULE_13]
    end else begin
      resp_word = {fix_status, device_mode, shown_code}; // [RULE_04] [RULE_11]
    end
  end

  // frame decode
  always_comb begin
    addr = rx_word[smr_pkg::ADDR_HI:smr_pkg::ADDR_LO];
    top = rx_word[smr_pkg::TOP_HI:smr_pkg::TOP_LO];
    wr_mode = rx_word[smr_pkg::MODE_HI:smr_pkg::MODE_LO];
    is_global = frame_done && addr == smr_pkg::MODE_ADDR && rx_word[smr_pkg::GLOBAL_BIT]
      && (top == smr_pkg::TOP_READ_CODE || top == smr_pkg::TOP_READ_STATE); // [RULE_01] [RULE_02]
    code_read = is_global && top == smr_pkg::TOP_READ_CODE
      && device_mode == smr_pkg::MODE_NORMAL; // [RULE_04]
    mode_wr = frame_done && top == smr_pkg::TOP_WRITE && addr == smr_pkg::MODE_ADDR;
    regu_wr = frame_done && top == smr_pkg::TOP_WRITE && addr == smr_pkg::REGU_ADDR; // [RULE_14]
    code_ok = !rnd_sel
      || (code_valid && rx_word[smr_pkg::CODE_HI:0] == ~last_code); // [RULE_20] [RULE_23]
    lp_off_req = wr_mode[smr_pkg::MODE_LP_BIT:2] == smr_pkg::MODE_LP_OFF_HEAD; // [RULE_06]
    lp_on_req = wr_mode[smr_pkg::MODE_LP_BIT];
    mode_accept = 1'b0;
    if (mode_wr) begin
      if (lp_off_req) begin
        mode_accept = device_mode == smr_pkg::MODE_NORMAL && code_ok
          && regulator_control[smr_pkg::OFF_EN_BIT]; // [RULE_19] [RULE_23]
      end else if (lp_on_req) begin
        mode_accept = device_mode == smr_pkg::MODE_NORMAL && code_ok; // [RULE_23]
      end else if (wr_mode == smr_pkg::MODE_NORMAL_REQ) begin
        mode_accept = device_mode[smr_pkg::MODE_LP_BIT]; // [RULE_21]
      end
    end
  end

  // mode, debug, fail-safe and code bookkeeping
  always_comb begin
    next_device_mode = device_mode;
    if (mode_load) begin
      next_device_mode = mode_load_value;
    end else if (mode_accept) begin
      next_device_mode = wr_mode;
    end
    next_rnd_sel = rnd_sel;
    if (device_mode == smr_pkg::MODE_INIT) begin
      next_rnd_sel = lowpower_random_select; // [RULE_03]
    end
    next_shown_code = frame_start ? rnd_code : shown_code;
    next_last_code = code_read ? shown_code : last_code;
    next_code_valid = code_valid;
    if (code_read) begin
      next_code_valid = 1'b1;
    end else if (mode_accept) begin
      next_code_valid = 1'b0;
    end
    next_strap_done = 1'b1;
    next_debug_mode = debug_mode;
    next_regulator_control = regulator_control;
    if (!strap_done) begin
      next_debug_mode = debug_strap;
      if (debug_strap) begin
        next_regulator_control[smr_pkg::CAN_HI:smr_pkg::CAN_LO] = smr_pkg::CAN_DEBUG_DEFAULT; // [RULE_16]
      end
    end else begin
      if (is_global && !rx_word[smr_pkg::SAFE_REL_BIT]) begin
        next_debug_mode = 1'b0; // [RULE_07] [RULE_09]
      end
      if (regu_wr) begin
        next_regulator_control = rx_word[smr_pkg::DATA_HI:0] & smr_pkg::REGU_WR_MASK; // [RULE_14]
      end
    end
    // fail-safe activation by hardware wins over a release in the same cycle
    next_safe_off = safe_off;
    if (safe_activate) begin
      next_safe_off = 1'b0;
    end else if (is_global && rx_word[smr_pkg::SAFE_REL_BIT]) begin
      next_safe_off = 1'b1; // [RULE_08] [RULE_10]
    end
    next_ballast_on = regulator_control[smr_pkg::BAL_EN_BIT] // [RULE_17]
      || (regulator_control[smr_pkg::BAL_AUTO_BIT] && load_over_threshold); // [RULE_18]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      device_mode <= smr_pkg::MODE_INIT;
      rnd_sel <= 1'b0;
      shown_code <= '0;
      last_code <= '0;
      code_valid <= 1'b0;
      strap_done <= 1'b0;
      debug_mode <= 1'b0;
      regulator_control <= smr_pkg::REGU_RESET; // [RULE_24]
      safe_off <= 1'b0;
      ballast_on <= 1'b0;
    end else begin
      device_mode <= next_device_mode;
      rnd_sel <= next_rnd_sel;
      shown_code <= next_shown_code;
      last_code <= next_last_code;
      code_valid <= next_code_valid;
      strap_done <= next_strap_done;
      debug_mode <= next_debug_mode;
      regulator_control <= next_regulator_control;
      safe_off <= next_safe_off;
      ballast_on <= next_ballast_on;
    end
  end

  // per supply: 0 aux, 1 can; fault blanking then shutdown
  for (genvar g = 0; g < 2; g++) begin : g_sup
    logic [1:0] field;
    logic [smr_pkg::BLANK_W-1:0] blank_cnt;
    logic [smr_pkg::BLANK_W-1:0] next_blank_cnt;
    logic [smr_pkg::BLANK_W-1:0] limit;
    logic shut;
    logic next_shut;
    logic next_on;
    logic next_flag;

    always_comb begin
      field = (g == 0) ? regulator_control[smr_pkg::AUX_HI:smr_pkg::AUX_LO]
        : regulator_control[smr_pkg::CAN_HI:smr_pkg::CAN_LO];
      limit = (field == smr_pkg::SUP_FAST) ? smr_pkg::BLANK_W'(smr_pkg::BLANK_SHORT_CYC)
        : smr_pkg::BLANK_W'(BLANK_LONG_CYCLES); // [RULE_15] [RULE_16]
      next_blank_cnt = blank_cnt;
      next_shut = shut;
      // an expiring blanking window wins over a register write in the same cycle
      if (field == smr_pkg::SUP_OFF) begin
        next_blank_cnt = '0;
        next_shut = 1'b0;
      end else if (supply_fault[g] && !shut && blank_cnt >= limit - smr_pkg::BLANK_W'(1)) begin
        next_shut = 1'b1;
      end else if (regu_wr) begin
        next_blank_cnt = '0;
        next_shut = 1'b0;
      end else if (!supply_fault[g]) begin
        next_blank_cnt = '0;
      end else if (!shut) begin
        next_blank_cnt = blank_cnt + smr_pkg::BLANK_W'(1);
      end
      next_on = field != smr_pkg::SUP_OFF && !next_shut; // [RULE_15] [RULE_16]
      next_flag = supply_fault[g] && (field == smr_pkg::SUP_REPORT || field == smr_pkg::SUP_FAST);
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        blank_cnt <= '0;
        shut <= 1'b0;
        supply_on[g] <= 1'b0;
        supply_flag[g] <= 1'b0;
      end else begin
        blank_cnt <= next_blank_cnt;
        shut <= next_shut;
        supply_on[g] <= next_on;
        supply_flag[g] <= next_flag;
      end
    end

    AST_BLANK_SHUTDOWN: assert property (@(posedge core_clk) disable iff (!rstn)
      supply_fault[g] && !regu_wr && field != smr_pkg::SUP_OFF && blank_cnt == limit - 1
      |=> !supply_on[g]) else $error("supply not shut after blanking"); // [RULE_15]
  end

  AST_LEAVE_DEBUG: assert property (@(posedge core_clk) disable iff (!rstn)
    strap_done && is_global && !rx_word[7] |=> !debug_mode)
    else $error("debug not left on global command"); // [RULE_07]
  AST_KEEP_DEBUG: assert property (@(posedge core_clk) disable iff (!rstn)
    strap_done && is_global && rx_word[7] |=> $stable(debug_mode))
    else $error("debug changed on release command"); // [RULE_10]
  AST_SAFE_RELEASE: assert property (@(posedge core_clk) disable iff (!rstn)
    is_global && rx_word[7] && !safe_activate |=> safe_off)
    else $error("fail-safe output not released"); // [RULE_08]
  AST_REGU_WRITE: assert property (@(posedge core_clk) disable iff (!rstn)
    strap_done && regu_wr |=> regulator_control == ($past(rx_word[7:0]) & 8'hdf))
    else $error("regulator register not loaded"); // [RULE_14]
  AST_OFF_GATE: assert property (@(posedge core_clk) disable iff (!rstn)
    !$past(mode_load) && device_mode[4:2] == 3'h3 && !$stable(device_mode)
    |-> $past(regulator_control[0])) else $error("supply-off entered while gated"); // [RULE_19]
  AST_CODE_GUARD: assert property (@(posedge core_clk) disable iff (!rstn)
    mode_wr && rnd_sel && rx_word[2:0] != ~last_code && !mode_load
    && (rx_word[7] || rx_word[7:5] == 3'h3) |=> $stable(device_mode))
    else $error("low-power write with wrong code taken"); // [RULE_23]
  AST_STATE_REPLY: assert property (@(posedge core_clk) disable iff (!rstn)
    lead_bits == 2'h3 |-> resp_word[1] == safe_off && resp_word[0] == debug_mode)
    else $error("state reply bits wrong"); // [RULE_12]
  AST_MODE_REPLY: assert property (@(posedge core_clk) disable iff (!rstn)
    frame_start |-> resp_word[7:3] == device_mode && resp_word[15:8] == fix_status)
    else $error("mode reply bits wrong"); // [RULE_11]
  AST_BALLAST: assert property (@(posedge core_clk) disable iff (!rstn)
    regulator_control[2] ##1 regulator_control[2] |-> ballast_on)
    else $error("ballast not enabled"); // [RULE_17]
endmodule : smr_mode_reg_ctrl

// *** testbench/smr_host_model.sv ***
`timescale 1ns/1ns
module smr_host_model (
  // clock
  input wire logic core_clk,
  // spi pins
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end

  // mode 0 master, three core cycles per sclk phase, msb first
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    @(negedge core_clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = tx[15-i];
      repeat (3) @(negedge core_clk);
      rx = {rx[14:0], miso};
      sclk = 1'b1;
      repeat (3) @(negedge core_clk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge core_clk);
    cs_n = 1'b1;
    // released data line must not hold its last value
    mosi = ~mosi;
    repeat (6) @(negedge core_clk);
  endtask : xfer
endmodule : smr_host_model

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  localparam int BLANK_SIM = 20;
  localparam logic [7:0] FIX = 8'ha5;
  logic core_clk, rstn, sclk, cs_n, mosi, miso;
  logic [7:0] fix_status;
  logic lowpower_random_select, debug_strap, safe_activate, mode_load;
  logic [4:0] mode_load_value;
  logic load_over_threshold;
  logic [1:0] supply_fault;
  logic [4:0] device_mode;
  logic debug_mode, safe_off, ballast_on;
  logic [7:0] regulator_control;
  logic [1:0] supply_on, supply_flag;
  logic [15:0] rx;
  logic [2:0] code;
  int err_total, checked, n1, n2;

  smr_mode_reg_ctrl #(.BLANK_LONG_CYCLES(BLANK_SIM)) u_smr_mode_reg_ctrl (
    .core_clk(core_clk), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .fix_status(fix_status), .lowpower_random_select(lowpower_random_select),
    .debug_strap(debug_strap), .safe_activate(safe_activate), .mode_load(mode_load),
    .mode_load_value(mode_load_value), .load_over_threshold(load_over_threshold),
    .supply_fault(supply_fault), .device_mode(device_mode), .debug_mode(debug_mode),
    .safe_off(safe_off), .regulator_control(regulator_control), .supply_on(supply_on),
    .supply_flag(supply_flag), .ballast_on(ballast_on));
  smr_host_model u_smr_host_model (
    .core_clk(core_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  function automatic logic [15:0] st();
    return {9'h000, device_mode, debug_mode, safe_off};
  endfunction : st

  function automatic logic [15:0] rep(input logic [4:0] m, input logic [2:0] low);
    return {FIX, m, low};
  endfunction : rep

  task automatic do_reset(input logic strap, input logic rnd);
    rstn = 1'b0;
    debug_strap = strap;
    lowpower_random_select = rnd;
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask : do_reset

  task automatic frame(input logic [15:0] tx);
    u_smr_host_model.xfer(tx, 16, rx);
  endtask : frame

  task automatic load_mode(input logic [4:0] m);
    mode_load_value = m;
    mode_load = 1'b1;
    @(negedge core_clk);
    mode_load = 1'b0;
    @(negedge core_clk);
  endtask : load_mode

  task automatic wait_low(input int idx, output int n);
    n = 0;
    while (supply_on[idx] !== 1'b0) begin
      @(negedge core_clk);
      n++;
      if (n > 400) begin
        err_total++;
        print_verdict();
      end
    end
  endtask : wait_low

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    print_verdict();
  end

  initial begin
    err_total = 0;
    checked = 0;
    rstn = 1'b0;
    fix_status = FIX;
    safe_activate = 1'b0;
    mode_load = 1'b0;
    mode_load_value = 5'h00;
    load_over_threshold = 1'b0;
    supply_fault = 2'h0;
    debug_strap = 1'b1;
    lowpower_random_select = 1'b0;
    @(negedge core_clk);
    do_reset(1'b1, 1'b0);
    check(st(), 16'h0002);
    check({8'h00, regulator_control}, 16'h0008);
    check({14'h0000, supply_on}, 16'h0002);
    $display("test reset done");

    frame(16'hdd80);
    check(rx, rep(5'h00, 3'b001));
    check(st(), 16'h0003);
    frame(16'hdd80);
    check(rx, rep(5'h00, 3'b011));
    frame(16'hdd00);
    check(st(), 16'h0001);
    frame(16'hdd00);
    check(rx, rep(5'h00, 3'b010));
    safe_activate = 1'b1;
    @(negedge core_clk);
    safe_activate = 1'b0;
    @(negedge core_clk);
    check(st(), 16'h0000);
    // global frame without bit 8, then a short frame: both refused
    frame(16'h1c80);
    u_smr_host_model.xfer(16'h1d80, 15, rx);
    check(st(), 16'h0000);
    frame(16'h1d80);
    check(st(), 16'h0001);
    check({3'h0, rx[15:3]}, {3'h0, FIX, 5'h00});
    $display("test debug and safe done");

    do_reset(1'b1, 1'b0);
    frame(16'h1d00);
    check(st(), 16'h0000);
    check({3'h0, rx[15:3]}, {3'h0, FIX, 5'h00});
    $display("test leave debug done");

    frame(16'h5fff);
    check({8'h00, regulator_control}, 16'h00df);
    check({15'h0000, ballast_on}, 16'h0001);
    frame(16'h5e02);
    check({15'h0000, ballast_on}, 16'h0000);
    check({14'h0000, supply_on}, 16'h0000);
    load_over_threshold = 1'b1;
    repeat (3) @(negedge core_clk);
    check({15'h0000, ballast_on}, 16'h0001);
    load_over_threshold = 1'b0;
    $display("test regulator done");

    frame(16'h5e98);
    check({14'h0000, supply_on}, 16'h0003);
    supply_fault = 2'h3;
    repeat (3) @(negedge core_clk);
    check({14'h0000, supply_flag}, 16'h0003);
    wait_low(0, n1);
    // three cycles of fault have already passed before counting starts
    check(16'((n1 + 3 >= BLANK_SIM - 1) && (n1 + 3 <= BLANK_SIM + 4)), 16'h0001);
    wait_low(1, n2);
    check(16'((n1 + n2 + 3 >= smr_pkg::BLANK_SHORT_CYC - 1)
      && (n1 + n2 + 3 <= smr_pkg::BLANK_SHORT_CYC + 5)), 16'h0001);
    supply_fault = 2'h0;
    frame(16'h5e48);
    supply_fault = 2'h3;
    repeat (3) @(negedge core_clk);
    check({14'h0000, supply_flag}, 16'h0000);
    supply_fault = 2'h0;
    $display("test supplies done");

    load_mode(5'h03);
    frame(16'h5e00);
    frame(16'h5c60);
    check(st(), 16'h000c);
    check({11'h000, rx[7:3]}, 16'h0003);
    frame(16'h5e01);
    // no wake source is raised here, so wake-up flags are already clear
    frame(16'h5c60);
    check(st(), 16'h0030);
    load_mode(5'h10);
    frame(16'h5c10);
    check(st(), 16'h0008);
    check({11'h000, rx[7:3]}, 16'h0010);
    $display("test low power done");

    do_reset(1'b0, 1'b1);
    frame(16'h5e01);
    load_mode(5'h03);
    frame(16'h1d00);
    code = rx[2:0];
    frame({13'h0b8c, code});
    check(st(), 16'h000c);
    frame({13'h0b8c, ~code});
    check(st(), 16'h0030);
    // supply-on low power: wrong code refused, inverted code taken
    load_mode(5'h03);
    frame(16'h1d00);
    code = rx[2:0];
    frame({13'h0b90, code});
    check(st(), 16'h000c);
    frame({13'h0b90, ~code});
    check(st(), 16'h0040);
    $display("test random code done");
    print_verdict();
  end
endmodule : tb_top
